// file: design/windowed_free_running_watchdog.sv
`include "wdg_defines.svh"
module windowed_free_running_watchdog
   import wdg_pkg::*;
#(
   parameter int DECR_CYCLES = `WDG_DECR_CYCLES
) (
   input  wire logic                   mclk,
   input  wire logic                   rst_n,
   input  wire logic                   optionHardware,
   input  wire logic                   haltMode,
   input  wire logic                   extWake,
   output logic                        resetPin_n,
   input  wire logic [`WDG_ADDR_W-1:0] s_axi_awaddr,
   input  wire logic [2:0]             s_axi_awprot,
   input  wire logic                   s_axi_awvalid,
   output logic                        s_axi_awready,
   input  wire logic [31:0]            s_axi_wdata,
   input  wire logic [3:0]             s_axi_wstrb,
   input  wire logic                   s_axi_wvalid,
   output logic                        s_axi_wready,
   output logic [1:0]                  s_axi_bresp,
   output logic                        s_axi_bvalid,
   input  wire logic                   s_axi_bready,
   input  wire logic [`WDG_ADDR_W-1:0] s_axi_araddr,
   input  wire logic [2:0]             s_axi_arprot,
   input  wire logic                   s_axi_arvalid,
   output logic                        s_axi_arready,
   output logic [31:0]                 s_axi_rdata,
   output logic [1:0]                  s_axi_rresp,
   output logic                        s_axi_rvalid,
   input  wire logic                   s_axi_rready
);

////////////////////////////////////////////////////////////////////////////////
   logic [`WDG_ADDR_W-1:0] awAddr;
   logic [31:0]            wData;
   logic [3:0]             wStrb;
   logic                   doWrite;
   logic                   ctrlWrite;
   logic                   activate;
   count_type              ctrlCount;
   logic                   hwMode;
   logic                   optCaught;
   logic                   effActive;
   logic                   tick;
   logic                   halted;
   logic                   wakePending;
   logic                   fire;
   logic                   next_fire;
   logic [31:0]            next_rdata;
   logic [1:0]             next_rresp;

   wdg_prescaler #(
      .DECR_CYCLES (DECR_CYCLES)
   ) u_prescaler (
      .mclk        (mclk),
      .rst_n       (rst_n),
      .haltMode    (haltMode),
      .extWake     (extWake),
      .tick        (tick),
      .halted      (halted),
      .wakePending (wakePending)
   );

   wdg_reset_pulse u_pulse (
      .mclk       (mclk),
      .rst_n      (rst_n),
      .fire       (fire),
      .resetPin_n (resetPin_n)
   );

////////////////////////////////////////////////////////////////////////////////
   // Write channel: address and data taken in either order, response after both
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_awready <= 1'b1;
         awAddr        <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         s_axi_awready <= 1'b0;
         awAddr        <= s_axi_awaddr;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_awready <= 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_wready <= 1'b1;
         wData        <= '0;
         wStrb        <= '0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         s_axi_wready <= 1'b0;
         wData        <= s_axi_wdata;
         wStrb        <= s_axi_wstrb;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_wready <= 1'b1;
      end
   end

   assign doWrite   = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
   assign ctrlWrite = doWrite && awAddr == `WDG_CTRL_ADDR && wStrb[0];

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `WDG_RESP_OKAY;
      end else if (doWrite) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= (awAddr == `WDG_CTRL_ADDR || awAddr == `WDG_STAT_ADDR) ?
                         `WDG_RESP_OKAY : `WDG_RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

////////////////////////////////////////////////////////////////////////////////
   // Read channel: one read outstanding, data one cycle after the address
   always_comb begin
      next_rdata = '0;
      next_rresp = `WDG_RESP_OKAY;
      if (s_axi_araddr == `WDG_CTRL_ADDR) begin
         next_rdata[7:0] = {activate, ctrlCount};
      end else if (s_axi_araddr == `WDG_STAT_ADDR) begin
         next_rdata[3:0] = {hwMode, wakePending, halted, effActive};
      end else begin
         next_rresp = `WDG_RESP_SLVERR;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= `WDG_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= next_rdata;
         s_axi_rresp   <= next_rresp;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

////////////////////////////////////////////////////////////////////////////////
   // Option strap caught once after reset release, never through the reset path
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         hwMode    <= 1'b0;
         optCaught <= 1'b0;
      end else if (!optCaught) begin
         hwMode    <= optionHardware;
         optCaught <= 1'b1;
      end
   end

   // Activate bit is sticky: a zero write cannot clear it
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         activate <= 1'(`WDG_CTRL_RESET >> `WDG_ACT_BIT);
      end else if (ctrlWrite && wData[`WDG_ACT_BIT]) begin
         activate <= 1'b1;
      end
   end

   assign effActive = hwMode || activate;

   // Free-running countdown; a software load beats the decrement in the same cycle
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ctrlCount <= count_type'(`WDG_CTRL_RESET);
      end else if (ctrlWrite) begin
         ctrlCount <= wData[6:0];
      end else if (tick) begin
         ctrlCount <= ctrlCount - 1'b1;
      end
   end

   // Reset is the watchdog's only action; there is no interrupt
   always_comb begin
      next_fire = 1'b0;
      if (ctrlWrite) begin
         next_fire = (effActive || wData[`WDG_ACT_BIT]) && !wData[`WDG_TOP_BIT];
      end else if (tick && ctrlCount == `WDG_TRIP_VALUE) begin
         next_fire = effActive;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         fire <= 1'b0;
      end else begin
         fire <= next_fire;
      end
   end

////////////////////////////////////////////////////////////////////////////////
   // Checking helpers
   logic [`WDG_PRESC_W-1:0] sinceTick;
   logic                    seenTick;
   logic                    firstCycle;
   logic [`WDG_PULSE_W-1:0] sinceFire;
   logic [`WDG_WAKE_W-1:0]  wakeLen;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sinceTick  <= '0;
         seenTick   <= 1'b0;
         firstCycle <= 1'b1;
      end else begin
         firstCycle <= 1'b0;
         if (tick) begin
            sinceTick <= '0;
            seenTick  <= 1'b1;
         end else if (halted || wakePending) begin
            seenTick  <= 1'b0;
         end else begin
            sinceTick <= sinceTick + 1'b1;
         end
      end
   end

   // Saturates so a long quiet spell never wraps into a false width
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sinceFire <= '1;
      end else if (fire) begin
         sinceFire <= '0;
      end else if (sinceFire != '1) begin
         sinceFire <= sinceFire + 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         wakeLen <= '0;
      end else if (wakePending) begin
         wakeLen <= wakeLen + 1'b1;
      end else begin
         wakeLen <= '0;
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   property p_decrement;
      tick && !ctrlWrite |=> ctrlCount == count_type'($past(ctrlCount) - 1'b1);
   endproperty
   a_decrement: assert property (p_decrement) else $error("count did not step down");

   property p_period;
      tick && seenTick |-> sinceTick == `WDG_PRESC_W'(DECR_CYCLES - 1);
   endproperty
   a_period: assert property (p_period) else $error("decrement period wrong");

   property p_trip;
      tick && !ctrlWrite && effActive && ctrlCount == `WDG_TRIP_VALUE
         |=> fire ##1 !resetPin_n;
   endproperty
   a_trip: assert property (p_trip) else $error("no reset on 40h to 3Fh");

   property p_pulse;
      $fell(resetPin_n) |-> !resetPin_n [*8];
   endproperty
   a_pulse: assert property (p_pulse) else $error("reset pulse too short");

   property p_inactive;
      !effActive && !(ctrlWrite && wData[`WDG_ACT_BIT]) |=> !fire;
   endproperty
   a_inactive: assert property (p_inactive) else $error("reset while inactive");

   property p_first;
      firstCycle |-> ctrlCount == 7'h7F && !activate;
   endproperty
   a_first: assert property (p_first) else $error("wrong reset value");

   property p_sticky;
      activate |=> activate;
   endproperty
   a_sticky: assert property (p_sticky) else $error("activate bit cleared");

   property p_swreset;
      ctrlWrite && wData[`WDG_ACT_BIT] && !wData[`WDG_TOP_BIT] |=> fire ##1 !resetPin_n;
   endproperty
   a_swreset: assert property (p_swreset) else $error("no software reset");

   property p_hw;
      hwMode && tick && !ctrlWrite && ctrlCount == `WDG_TRIP_VALUE |=> fire;
   endproperty
   a_hw: assert property (p_hw) else $error("hardware option did not trip");

   property p_halt;
      halted && !ctrlWrite |=> $stable(ctrlCount) && !fire;
   endproperty
   a_halt: assert property (p_halt) else $error("count moved in halt");

   property p_wake;
      $rose(wakePending) |-> !tick [*8];
   endproperty
   a_wake: assert property (p_wake) else $error("counting right after wake");

   property p_read;
      s_axi_arvalid && s_axi_arready && s_axi_araddr == `WDG_CTRL_ADDR
         |=> s_axi_rvalid && s_axi_rdata[6:0] == $past(ctrlCount);
   endproperty
   a_read: assert property (p_read) else $error("count readback wrong");

   property p_bresp;
      doWrite && awAddr == `WDG_CTRL_ADDR |=> s_axi_bvalid && s_axi_bresp == `WDG_RESP_OKAY;
   endproperty
   a_bresp: assert property (p_bresp) else $error("write response missing");

   property p_bhold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_bhold: assert property (p_bhold) else $error("write response dropped");

   property p_rdhold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_rdhold: assert property (p_rdhold) else $error("read data dropped");

   property p_load;
      ctrlWrite |=> ctrlCount == wData[6:0];
   endproperty
   a_load: assert property (p_load) else $error("count not loaded");

   property p_option;
      optCaught |=> $stable(hwMode);
   endproperty
   a_option: assert property (p_option) else $error("option changed after reset");

   property p_wake_quiet;
      wakePending |-> !tick;
   endproperty
   a_wake_quiet: assert property (p_wake_quiet) else $error("tick during wake delay");

   property p_wake_len;
      $fell(wakePending) |-> wakeLen == `WDG_WAKE_W'(`WDG_WAKE_CYCLES);
   endproperty
   a_wake_len: assert property (p_wake_len) else $error("wake delay length wrong");

   property p_pulse_len;
      $rose(resetPin_n) |-> sinceFire == `WDG_PULSE_W'(`WDG_RST_PULSE_CYCLES);
   endproperty
   a_pulse_len: assert property (p_pulse_len) else $error("reset pulse width wrong");
endmodule

// file: design/wdg_defines.svh
`ifndef WDG_DEFINES_SVH
`define WDG_DEFINES_SVH
// Operation
// - The 7-bit countdown drops by one every 65,536 clock cycles.
// - Active watchdog, count passing 40h to 3Fh, drives reset pin low about 500ns.
// - Countdown runs even when inactive; inactive watchdog never resets.
// - At 8 MHz, FFh gives 524.288 ms and C0h gives 8.192 ms.
// - Software option: watchdog inactive after every reset.
// - Once activated no write deactivates it; only reset does.
// - Write with activate set and top bit clear resets at once.
// - Hardware option: always active, stored activate bit ignored.
// - Wait has no effect; halt freezes counter and blocks watchdog reset.
// - After halt wake by interrupt, counting resumes after 514 clocks.
// - Reset ending halt returns software watchdog to inactive state.
// - Control register resets to 7Fh.
// - Activate bit 7 set by software, cleared only by reset; zero write ignored.
// - Bits 6:0 read current count; writing them loads a new count.

////////////////////////////////////////////////////////////////////////////////
`define WDG_ADDR_W        8
`define WDG_CTRL_INDEX    8'h0D
`define WDG_STAT_INDEX    8'h0E
`define WDG_CTRL_ADDR     (8'(`WDG_CTRL_INDEX * 8'h04))
`define WDG_STAT_ADDR     (8'(`WDG_STAT_INDEX * 8'h04))
`define WDG_CTRL_RESET    8'h7F
`define WDG_ACT_BIT       7
`define WDG_TOP_BIT       6
`define WDG_TRIP_VALUE    7'h40
`define WDG_DECR_CYCLES   65536
`define WDG_PRESC_W       17
`define WDG_WAKE_CYCLES   514
`define WDG_WAKE_W        10
`define WDG_RST_PULSE_NS  500
`define WDG_CLK_PERIOD_NS 4
`define WDG_RST_PULSE_CYCLES (`WDG_RST_PULSE_NS / `WDG_CLK_PERIOD_NS)
`define WDG_PULSE_W       8
`define WDG_RESP_OKAY     2'h0
`define WDG_RESP_SLVERR   2'h2
`endif

// file: design/wdg_pkg.sv
package wdg_pkg;
   typedef enum logic [2:0] {
      RUN_ST  = 3'b001,
      HALT_ST = 3'b010,
      WAKE_ST = 3'b100
   } halt_state_type;
   typedef logic [6:0] count_type;
endpackage

// file: design/wdg_prescaler.sv
`include "wdg_defines.svh"
module wdg_prescaler
   import wdg_pkg::*;
#(
   parameter int DECR_CYCLES = `WDG_DECR_CYCLES
) (
   input  wire logic mclk,
   input  wire logic rst_n,
   input  wire logic haltMode,
   input  wire logic extWake,
   output logic      tick,
   output logic      halted,
   output logic      wakePending
);
   halt_state_type          state;
   logic [`WDG_PRESC_W-1:0] presc;
   logic [`WDG_WAKE_W-1:0]  wakeCnt;

   // Halt freezes everything; only an external wake or reset leaves it
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state   <= RUN_ST;
         wakeCnt <= '0;
      end else begin
         unique case (state)
            RUN_ST: begin
               if (haltMode) begin
                  state <= HALT_ST;
               end
            end
            HALT_ST: begin
               if (extWake) begin
                  state   <= WAKE_ST;
                  wakeCnt <= '0;
               end
            end
            WAKE_ST: begin
               if (wakeCnt == `WDG_WAKE_W'(`WDG_WAKE_CYCLES - 1)) begin
                  state <= RUN_ST;
               end else begin
                  wakeCnt <= wakeCnt + 1'b1;
               end
            end
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         presc <= '0;
         tick  <= 1'b0;
      end else if (state == RUN_ST && !haltMode) begin
         if (presc == `WDG_PRESC_W'(DECR_CYCLES - 1)) begin
            presc <= '0;
            tick  <= 1'b1;
         end else begin
            presc <= presc + 1'b1;
            tick  <= 1'b0;
         end
      end else begin
         tick <= 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         halted      <= 1'b0;
         wakePending <= 1'b0;
      end else begin
         halted      <= (state == HALT_ST) || (state == RUN_ST && haltMode);
         wakePending <= (state == HALT_ST && extWake) ||
                        (state == WAKE_ST && wakeCnt != `WDG_WAKE_W'(`WDG_WAKE_CYCLES - 1));
      end
   end
endmodule

// file: design/wdg_reset_pulse.sv
`include "wdg_defines.svh"
module wdg_reset_pulse (
   input  wire logic mclk,
   input  wire logic rst_n,
   input  wire logic fire,
   output logic      resetPin_n
);
   logic [`WDG_PULSE_W-1:0] remain;

   // A new trigger during the pulse restarts the full width
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         remain     <= '0;
         resetPin_n <= 1'b1;
      end else if (fire) begin
         remain     <= `WDG_PULSE_W'(`WDG_RST_PULSE_CYCLES - 1);
         resetPin_n <= 1'b0;
      end else if (remain != '0) begin
         remain     <= remain - 1'b1;
         resetPin_n <= 1'b0;
      end else begin
         resetPin_n <= 1'b1;
      end
   end
endmodule

// file: verif/windowed_free_running_watchdog_tb.sv
`include "wdg_defines.svh"
module windowed_free_running_watchdog_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import wdg_pkg::*;

   // Short prescale period keeps a full countdown within a few hundred cycles
   localparam int DECR = 8;
   localparam logic [1:0] OKAY = `WDG_RESP_OKAY;
   localparam logic [1:0] SLVERR = `WDG_RESP_SLVERR;
   localparam logic [7:0] CTRL = `WDG_CTRL_ADDR;
   localparam logic [7:0] STAT = `WDG_STAT_ADDR;

   typedef struct {
      logic [31:0] d;
      logic [31:0] m;
      logic [1:0]  r;
   } rdExp_type;

   logic        mclk, rst_n, optionHardware, haltMode, extWake, resetPin_n;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [2:0]  s_axi_awprot, s_axi_arprot;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready;
   rdExp_type   rdQ[$];
   rdExp_type   rdE;
   logic [1:0]  wrQ[$];
   int          n_fail, checked, cyc, n, lo;

   windowed_free_running_watchdog #(.DECR_CYCLES(DECR)) DUT (
      .mclk, .rst_n, .optionHardware, .haltMode, .extWake, .resetPin_n,
      .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
   );

   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // Hang guard: the whole sequence needs roughly 2000 cycles
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         summarize();
      end
   end

   // Scoreboard: oldest note is compared whenever a response is taken
   always @(posedge mclk) begin
      if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
         if (rdQ.size() == 0) begin
            check("unexpected read", 32'h1, 32'h0);
         end else begin
            rdE = rdQ.pop_front();
            check("rdata", s_axi_rdata & rdE.m, rdE.d);
            check("rresp", {30'h0, s_axi_rresp}, {30'h0, rdE.r});
         end
      end
      if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) begin
         if (wrQ.size() == 0) begin
            check("unexpected write", 32'h1, 32'h0);
         end else begin
            check("bresp", {30'h0, s_axi_bresp}, {30'h0, wrQ.pop_front()});
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                     input logic [1:0] r);
      wrQ.push_back(r);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge mclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      @(posedge mclk);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
                     input logic [1:0] r);
      rdQ.push_back('{d: d, m: m, r: r});
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge mclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      @(posedge mclk);
   endtask

   // Counts edges until the reset pin shows the wanted level, up to a limit
   task automatic waitPin(input logic lvl, input int lim, output int cnt);
      cnt = 0;
      while (resetPin_n !== lvl && cnt < lim) begin
         @(posedge mclk);
         cnt++;
      end
   endtask

   task automatic rstPulse();
      rst_n <= 1'b0;
      haltMode <= 1'b0;
      extWake <= 1'b0;
      repeat (4) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (2) @(posedge mclk);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      {rst_n, optionHardware, haltMode, extWake, cyc, n_fail, checked} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata} = '0;
      {s_axi_wstrb, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_arvalid, s_axi_rready} = '0;
      void'($urandom(32'h01A4FB72));
      repeat (4) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (2) @(posedge mclk);
      rd(CTRL, 32'h7F, 32'hFFFFFFFF, OKAY);
      rd(STAT, 32'h0, 32'h0F, OKAY);
      rd(8'h00, 32'h0, 32'hFFFFFFFF, SLVERR);
      wr(8'h3C, 32'hFF, 4'hF, SLVERR);
      wr(CTRL, 32'hFF, 4'h0, OKAY);
      wr(STAT, 32'hFF, 4'hF, OKAY);
      rd(CTRL, 32'h0, 32'h80, OKAY);
      $display("test map done");
      wr(CTRL, 32'h55, 4'h1, OKAY);
      rd(CTRL, 32'h54, 32'hFE, OKAY);
      wr(CTRL, 32'h41, 4'h1, OKAY);
      waitPin(1'b0, 300, n);
      check("inactive pin quiet", 32'(n), 32'd300);
      rd(CTRL, 32'h0, 32'hC0, OKAY);
      $display("test free run done");
      wr(CTRL, 32'hFF, 4'h1, OKAY);
      wr(CTRL, 32'h7F, 4'h1, OKAY);
      rd(CTRL, 32'h80, 32'h80, OKAY);
      rd(STAT, 32'h1, 32'h1, OKAY);
      wr(CTRL, 32'h85, 4'h1, OKAY);
      waitPin(1'b0, 20, n);
      check("soft reset delay", 32'(n <= 3), 32'h1);
      waitPin(1'b1, 300, n);
      check("pin low width", 32'(n), 32'd125);
      rstPulse();
      rd(CTRL, 32'h7F, 32'hFF, OKAY);
      $display("test lock done");
      for (int i = 0; i < 3; i++) begin
         lo = $urandom_range(3, 0);
         wr(CTRL, 32'h000000C0 | 32'(lo), 4'h1, OKAY);
         waitPin(1'b0, 100, n);
         check("trip delay", 32'(n >= DECR * lo && n <= DECR * lo + 10), 32'h1);
         waitPin(1'b1, 300, n);
         check("trip pin width", 32'(n), 32'd125);
         rstPulse();
      end
      $display("test trip done");
      optionHardware <= 1'b1;
      rstPulse();
      rd(STAT, 32'h9, 32'h9, OKAY);
      wr(CTRL, 32'h40, 4'h1, OKAY);
      waitPin(1'b0, 40, n);
      check("hardware trip", 32'(n <= DECR + 2), 32'h1);
      optionHardware <= 1'b0;
      rstPulse();
      $display("test hardware done");
      wr(CTRL, 32'hC1, 4'h1, OKAY);
      haltMode <= 1'b1;
      waitPin(1'b0, 200, n);
      check("halt pin quiet", 32'(n), 32'd200);
      rd(STAT, 32'h2, 32'h2, OKAY);
      rd(CTRL, 32'hC0, 32'hFE, OKAY);
      haltMode <= 1'b0;
      extWake <= 1'b1;
      @(posedge mclk);
      extWake <= 1'b0;
      waitPin(1'b0, 700, n);
      check("wake delay", 32'(n >= 514 && n <= 540), 32'h1);
      rstPulse();
      $display("test halt wake done");
      wr(CTRL, 32'hFF, 4'h1, OKAY);
      haltMode <= 1'b1;
      repeat (20) @(posedge mclk);
      rstPulse();
      rd(CTRL, 32'h7F, 32'hFF, OKAY);
      rd(STAT, 32'h0, 32'hF, OKAY);
      $display("test halt reset done");
      summarize();
   end
endmodule
